/* File: src/bios_shadow_pkg.sv */
package bios_shadow_pkg;
    // configuration space
    localparam logic [7:0] attr_offset = 8'h5b;
    localparam logic [7:0] attr_reset = 8'h00;
    localparam logic [7:0] attr_rw_mask = 8'h33;
    // field positions
    localparam int upper_we_bit = 5;
    localparam int upper_re_bit = 4;
    localparam int lower_we_bit = 1;
    localparam int lower_re_bit = 0;
    // windows, 16 kb each, address bits 31:14 select the window
    localparam logic [31:0] lower_window_base = 32'h000c8000;
    localparam logic [31:0] upper_window_base = 32'h000cc000;
    localparam int window_lsb = 14;
    // routing decision
    typedef enum logic [1:0] {
        route_none = 2'b00,
        route_dram = 2'b01,
        route_hub = 2'b10
    } route_t;
endpackage

/* File: src/window_route.sv */
`timescale 1ns/10ps
// steering decision for one window from its two enable bits
module window_route
    import bios_shadow_pkg::*;
(
    // cycle
    input wire logic hit,
    input wire logic is_write,
    // enable field, write enable high bit, read enable low bit
    input wire logic [1:0] field,
    // decision
    output route_t route
);
    wire logic dram_ok;

    // 00 hub only, 01 reads dram, 10 writes dram, 11 both dram
    assign dram_ok = is_write ? field[1] : field[0];
    assign route = !hit ? route_none : (dram_ok ? route_dram : route_hub);
endmodule

/* File: src/bios_shadow_region_steering.sv */
`timescale 1ns/10ps
// Summary of operation
// - bits 5:4 steer window 0cc000h-0cffffh
// - bits 1:0 steer window 0c8000h-0cbfffh
// - upper: bit5 write enable, bit4 read
// - lower: bit1 write enable, bit0 read
// - field 00: all cycles to hub
// - field 01: reads dram, writes hub
// - field 10: writes dram, reads hub
// - field 11: reads and writes dram
// - 8-bit register at 5bh, resets zero
module bios_shadow_region_steering
    import bios_shadow_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // host memory cycle
    input wire logic cyc_valid,
    input wire logic cyc_write,
    input wire logic [31:0] cyc_addr,
    // steering result, one cycle after the request
    output logic to_dram,
    output logic to_legacy_hub_link,
    output logic steer_valid,
    // field state for observation
    output logic [1:0] upper_window_enable,
    output logic [1:0] lower_window_enable
);
    // two windows share this one register; index 0 is the low one
    localparam int n_windows = 2;

    // attribute register and its next value
    logic [7:0] attr_q;
    logic [7:0] attr_d;
    // source of the registered read data
    logic [7:0] rdata_d;

    // configuration decode
    wire logic sel;
    wire logic wr_hit;
    wire logic rd_hit;
    wire logic [7:0] wdata_kept;
    wire logic [7:0] attr_view;

    // per-window decode, one entry per window
    wire logic [31:0] win_base [n_windows];
    wire logic [1:0] win_field [n_windows];
    wire logic win_hit [n_windows];
    route_t win_route [n_windows];
    wire logic [n_windows-1:0] win_dram;
    wire logic [n_windows-1:0] win_hub;
    wire logic [n_windows-1:0] win_any;

    // next values of the steering flops
    wire logic dram_d;
    wire logic hub_d;
    wire logic valid_d;

    // next values of the field copies
    wire logic [1:0] upper_en_d;
    wire logic [1:0] lower_en_d;

    // how a host cycle is steered:
    //   - the address picks at most one window (16 kb each)
    //   - the window picks its 2-bit field from the register
    //   - writes look at the write enable, reads at the read enable
    //   - enable set: cycle goes to dram; clear: to the hub link
    // cycles outside both windows are not ours to steer, so all
    // three flags stay low and the host side decides elsewhere

    // field codes, per window:
    //   00  reads and writes both go to the hub link
    //   01  reads from dram, writes to the hub link
    //   10  writes to dram, reads from the hub link
    //   11  reads and writes both from dram
    // 01 lets firmware run from a shadow copy while writes still
    // reach the original device; 10 is handy while copying into it

    // limitation: only these two windows are decoded; the other
    // legacy ranges have attribute registers of their own

    // window membership; only bits above the 16 kb offset count
    function automatic logic in_window(
        input logic [31:0] addr,
        input logic [31:0] base
    );
        in_window = (addr[31:window_lsb] == base[31:window_lsb]);
    endfunction

    // one window's field as {write enable, read enable}
    function automatic logic [1:0] field_of(
        input logic [7:0] attr,
        input logic upper
    );
        logic [1:0] f;
        f = {attr[lower_we_bit], attr[lower_re_bit]};
        if (upper) begin
            f = {attr[upper_we_bit], attr[upper_re_bit]};
        end
        field_of = f;
    endfunction

    // the register answers at one offset only; other offsets read
    // zero and writes to them change nothing here
    assign sel = (cfg_addr == attr_offset);
    assign wr_hit = cfg_wr && sel;
    assign rd_hit = cfg_rd && sel;

    // reserved bits are dropped on the way in, so they can never
    // reach the steering decode later on
    assign wdata_kept = cfg_wdata & attr_rw_mask;
    assign attr_d = wr_hit ? wdata_kept : attr_q;

    // read view masked too, in case a reserved bit ever stores
    assign attr_view = attr_q & attr_rw_mask;

    // read and write in one cycle return the old value; the
    // new one is only visible from the next read on
    assign rdata_d = rd_hit ? attr_view : 8'h00;

    // window bases, low window first
    assign win_base[0] = lower_window_base;
    assign win_base[1] = upper_window_base;

    // one decode and one steering unit per window
    for (genvar i = 0; i < n_windows; i++) begin : g_win
        // an idle host bus steers nothing, whatever the address
        assign win_hit[i] = cyc_valid && in_window(cyc_addr, win_base[i]);
        // field comes from the stored register, so a write in the
        // same cycle only affects the next host cycle
        assign win_field[i] = field_of(attr_q, (i == 1));

        window_route u_route (
            .hit(win_hit[i]),
            .is_write(cyc_write),
            .field(win_field[i]),
            .route(win_route[i])
        );

        // flatten the decision into plain flags for the combine
        assign win_dram[i] = (win_route[i] == route_dram);
        assign win_hub[i] = (win_route[i] == route_hub);
        assign win_any[i] = win_hit[i];
    end

    // windows are disjoint, so at most one of the dram and hub flags is set per cycle;
    // a miss sets none and leaves both paths quiet
    assign dram_d = |win_dram;
    assign hub_d = |win_hub;
    assign valid_d = |win_any;

    // copies follow the next register value, so they change on
    // the same edge as the register and never lag behind it
    assign upper_en_d = field_of(attr_d, 1'b1);
    assign lower_en_d = field_of(attr_d, 1'b0);

    // attribute register; reset leaves both windows on the hub
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            attr_q <= attr_reset;
        end else begin
            attr_q <= attr_d;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 8'h00;
        end else begin
            cfg_rdata <= rdata_d;
        end
    end

    // dram flag, one cycle after the host cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            to_dram <= 1'b0;
        end else begin
            to_dram <= dram_d;
        end
    end

    // hub flag; after reset every window hit lands here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            to_legacy_hub_link <= 1'b0;
        end else begin
            to_legacy_hub_link <= hub_d;
        end
    end

    // qualifier for the two flags, high for any window hit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            steer_valid <= 1'b0;
        end else begin
            steer_valid <= valid_d;
        end
    end

    // upper field copy for observation of the register state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            upper_window_enable <= attr_reset[upper_we_bit:upper_re_bit];
        end else begin
            upper_window_enable <= upper_en_d;
        end
    end

    // lower field copy for observation of the register state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lower_window_enable <= attr_reset[lower_we_bit:lower_re_bit];
        end else begin
            lower_window_enable <= lower_en_d;
        end
    end
endmodule

/* File: tb/steer_checker.sv */
`timescale 1ns/10ps
module steer_checker import bios_shadow_pkg::*; (
    input wire logic clk_sys, rst, cfg_wr, cfg_rd, cyc_valid, cyc_write,
    input wire logic to_dram, to_legacy_hub_link, steer_valid,
    input wire logic [7:0] cfg_addr, cfg_rdata,
    input wire logic [31:0] cyc_addr,
    input wire logic [1:0] upper_window_enable, lower_window_enable);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // compare of address bits 31:14 only, 16 kb per window
    wire s = cfg_addr == attr_offset, rs = s && cfg_rd, ws = s && cfg_wr;
    wire hi = cyc_addr[31:14] == 18'h33;
    wire hit = cyc_valid && (hi || cyc_addr[31:14] == 18'h32);
    wire [1:0] f = hi ? upper_window_enable : lower_window_enable;
    wire dh = hit && f[cyc_write], hh = hit && !f[cyc_write];
    wire [7:0] m = {2'h0, upper_window_enable, 2'h0, lower_window_enable};
    wire [7:0] q = cfg_rdata;
    wire sv = steer_valid, dr = to_dram, hb = to_legacy_hub_link;
    hit_sv_a: assert property (hit |=> sv) else $error("lost");
    miss_off_a: assert property (!hit |=> !sv) else $error("miss");
    one_way_a: assert property (sv == (dr ^ hb)) else $error("both");
    dram_go_a: assert property (dh |=> dr && !hb) else $error("dr");
    hub_go_a: assert property (hh |=> hb && !dr) else $error("hub");
    rd_back_a: assert property (rs |=> q == $past(m)) else $error("rd");
    rd_idle_a: assert property (!rs |=> q == 8'h00) else $error("q");
    wr_hold_a: assert property (!ws |=> $stable(m)) else $error("wr");
endmodule
bind bios_shadow_region_steering steer_checker chk (.*);

/* File: tb/host_model.sv */
`timescale 1ns/10ps
// host cycles; an idle address shows the inverse, never a stale value
module host_model (input wire logic clk_sys, output logic cyc_valid = 0,
    output logic cyc_write = 0, output logic [31:0] cyc_addr = 0);
    task go(logic w, logic [31:0] a);
        {cyc_valid, cyc_write, cyc_addr} = {1'b1, w, a};
        @(posedge clk_sys) #1 {cyc_valid, cyc_addr} = {1'b0, ~a};
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench import bios_shadow_pkg::*; ;
    logic clk_sys = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, cyc_valid, cyc_write;
    logic to_dram, to_legacy_hub_link, steer_valid;
    logic [7:0] cfg_addr = 0, cfg_wdata = 0, cfg_rdata;
    logic [31:0] cyc_addr;
    logic [1:0] upper_window_enable, lower_window_enable;
    int n_fail = 0, checked = 0, t = 0;
    logic [7:0] rd;
    wire [7:0] so = {5'h0, steer_valid, to_dram, to_legacy_hub_link};
    bios_shadow_region_steering DUT (.*);
    host_model h (.*);
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++t > 300) end_of_test(1);
    task end_of_test(int e);
        n_fail += e;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(logic [7:0] s, e);
        checked++;
        if (s !== e) begin n_fail++; $display("Error %0t %h %h", $time, s, e); end
    endtask
    // read data is taken one edge after the strobe; an idle edge follows
    task cf(logic wr, logic [7:0] a, d, output logic [7:0] r);
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {wr, !wr, a, d};
        @(posedge clk_sys) #1 r = cfg_rdata;
        {cfg_wr, cfg_rd} = 2'h0;
        @(posedge clk_sys) #1;
    endtask
    // flags stand one cycle, then drop with the idle edge
    task st(logic w, logic [31:0] a, logic [2:0] e);
        h.go(w, a);
        chk(so, {5'h0, e});
        @(posedge clk_sys) #1;
        chk(so, 8'h00);
    endtask
    // reset state, window edges, a foreign offset
    task t_reset;
        st(1, 32'h000cc000, 3'h5); st(0, 32'h000cbfff, 3'h5);
        st(0, 32'h000c7fff, 3'h0); st(1, 32'h000d0000, 3'h0);
        cf(1, 8'h5c, 8'hff, rd);
        cf(0, 8'h5c, 8'h00, rd);
        chk(rd, 8'h00);
        cf(0, attr_offset, 8'h00, rd);
        chk(rd, 8'h00);
    endtask
    // lower holds the inverse code, so a swapped field shows
    task t_codes;
        for (int c = 0; c < 4; c++) begin
            cf(1, attr_offset, {2'h3, c[1:0], 2'h3, ~c[1:0]}, rd);
            cf(0, attr_offset, 8'h00, rd);
            chk(rd, {2'h0, c[1:0], 2'h0, ~c[1:0]});
            for (int w = 0; w < 2; w++) begin
                st(w[0], 32'h000cc000, {1'b1, c[w], !c[w]});
                st(w[0], 32'h000cbfff, {1'b1, !c[w], c[w]});
                st(w[0], 32'h000cffff, {1'b1, c[w], !c[w]});
                st(w[0], 32'h000c8000, {1'b1, !c[w], c[w]});
            end
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 rst = 0;
        t_reset;
        t_codes;
        end_of_test(0);
    end
endmodule
